// [src/pin_io_pkg.sv]
/*
 * constants, enums and register map for the shared-pin i/o block.
 * assumes: single clock domain at 100 mhz, byte-wide register port.
 */
package pin_io_pkg;
    // register map (byte offsets on the plain register port)
    localparam logic [3:0] REG_PORT_DATA   = 4'h0; // port output latch
    localparam logic [3:0] REG_PORT_DIR    = 4'h1; // direction, 1 = output
    localparam logic [3:0] REG_FILTER_CTRL = 4'h2; // irq_filter_ctrl
    localparam logic [3:0] REG_NMI_CTRL    = 4'h3; // nmi_enable_latch
    localparam logic [3:0] REG_CUTOFF_CTRL = 4'h4; // cutoff + serial disable
    localparam logic [3:0] REG_MODE_CTRL   = 4'h5; // processor mode switch
    localparam logic [3:0] REG_STATUS      = 4'h6; // raw and filtered pins
    localparam logic [3:0] REG_PIN_LEVEL   = 4'h7; // raw port pin levels

    localparam int PORT_W = 8;             // pins in the port
    localparam int SEL_W  = 3;             // filter_clock_select width
    localparam int DIV_W  = 8;             // sampling prescaler width
    localparam int MOTOR_PINS = 6;         // three-phase pins
    localparam int OD_PINS = 3;            // open-drain pins

    // field positions
    localparam int CUT_EN_BIT  = 0;        // cutoff_by_input_enable
    localparam int SOD_BIT     = 1;        // serial_out_disable
    localparam int TP_EN_BIT   = 2;        // three_phase_enable
    localparam int TP_OE_BIT   = 3;        // three_phase_output_enable
    localparam int MODE_BIT    = 0;        // bus mode chosen by software
    localparam int ST_RAW_BIT  = 0;
    localparam int ST_FILT_BIT = 1;
    localparam int ST_NMI_BIT  = 2;
    localparam int ST_PU_BIT   = 3;

    // reset values
    localparam logic [PORT_W-1:0] DIR_RESET  = 8'h00;
    localparam logic [PORT_W-1:0] DATA_RESET = 8'h00;
    localparam logic [SEL_W-1:0]  SEL_RESET  = 3'h0;

    // boot-mode pull-up window: two low-speed oscillator cycles
    localparam int LOCO_NS      = 8000;    // low-speed osc period, ns
    localparam int CLK_NS       = 10;      // system clock period, ns
    localparam int PULLUP_LOCO  = 2;
    localparam int PULLUP_CYC   = PULLUP_LOCO * LOCO_NS / CLK_NS;
    localparam int PU_CNT_W     = 11;

    // filter needs this many equal samples
    localparam int MATCH_COUNT  = 3;

    // pin role of each port bit
    typedef enum logic [1:0] {
        ROLE_GPIO,
        ROLE_PERIPH,
        ROLE_PWM,
        ROLE_DAC
    } pin_role_t;
endpackage

// [src/nmi_digital_filter.sv]
/*
 * three-equal-sample digital filter for the interrupt/shutdown pin.
 * assumes: pin input is synchronous to clk.
 */
`timescale 1ns/10ps
`default_nettype none
module nmi_digital_filter
    import pin_io_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [SEL_W-1:0] filter_clock_select,
    input  wire logic             pin_level,
    output logic                  filtered
);
    logic [DIV_W-1:0]       prescale;   // free-running divider
    logic [MATCH_COUNT-1:0] history;    // last samples, newest in bit 0
    logic                   tick;       // one sampling clock period

    // sampling clock: divide by 2^sel
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    // tick when low sel bits of divider are all ones
    always_comb begin
        tick = ((prescale | ~((DIV_W'(1) << filter_clock_select)
                - DIV_W'(1))) == '1); // [RULE5]
    end

    // shift one sample per sampling clock, history resets high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            history <= '1; // [RULE18]
        end else if (tick) begin
            history <= {history[MATCH_COUNT-2:0], pin_level}; // [RULE5]
        end
    end

    // pass level only after three equal samples
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filtered <= 1'b1; // [RULE18]
        end else if (history == '1) begin
            filtered <= 1'b1; // [RULE6]
        end else if (history == '0) begin
            filtered <= 1'b0; // [RULE6]
        end
    end

    a_filter_low_pass: assert property ( // [RULE6]
        @(posedge clk) disable iff (rst)
        $fell(filtered) |-> $past(history) == '0)
        else $error("filter fell without three low samples");

    a_filter_high_pass: assert property ( // [RULE6]
        @(posedge clk) disable iff (rst)
        $rose(filtered) |-> $past(history) == '1)
        else $error("filter rose without three high samples");

    a_filter_holds_mixed: assert property ( // [RULE6]
        @(posedge clk) disable iff (rst)
        (history != '0 && history != '1) |=> $stable(filtered))
        else $error("filter changed on mixed samples");
endmodule
`default_nettype wire

// [src/boot_pullup_timer.sv]
/*
 * boot-mode pin pull-up window after reset.
 * assumes: rst covers watchdog, hardware, power-on, monitor-0 resets.
 */
`timescale 1ns/10ps
`default_nettype none
module boot_pullup_timer
    import pin_io_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    output logic      pullup_on
);
    logic [PU_CNT_W-1:0] count; // cycles left in pull-up window

    // count down the window, pull-up stays while nonzero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= PU_CNT_W'(PULLUP_CYC); // [RULE9]
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    // pull-up active during reset and for the window after
    always_comb begin
        pullup_on = (count != '0); // [RULE9]
    end

    a_pullup_window: assert property ( // [RULE9]
        @(posedge clk) disable iff (rst)
        $fell(pullup_on) |-> $past(count) == PU_CNT_W'(1))
        else $error("pull-up window ended early");
endmodule
`default_nettype wire

// [src/shared_pin_io.sv]
/*
 * shared-pin port logic: direction vs peripheral i/o, input fan-out,
 * interrupt/shutdown filter, forced high impedance, boot pull-up.
 * assumes: pins are resolved outside from out/oe, inputs synchronous.
 */
// Functional notes
// RULE1 - ordinary peripheral outputs ignore direction bit
// RULE2 - software sets direction for pwm, dac, inputs
// RULE3 - same pin level goes to every input user
// RULE4 - driven pin level feeds other peripheral input
// RULE5 - filter samples once per selected sampling clock
// RULE6 - filter passes level after three equal samples
// RULE7 - port input reads raw pin, unfiltered
// RULE8 - no wait or stop while filtering
// RULE9 - boot pin pull-up after reset, brief
// RULE10 - cutoff enable plus low shutdown floats motor pins
// RULE11 - serial output disable floats serial pin
// RULE12 - software avoids upper port registers on small package
// RULE13 - ports start as inputs after reset
// RULE14 - boot pin low keeps bus ports input; code holds ports input only until the strap is taken
// RULE15 - open-drain bits drive low only
// RULE16 - filter control changed only while safe
// RULE17 - nmi enable, once set, stays set
// RULE18 - filter history resets to inactive high
`timescale 1ns/10ps
`default_nettype none
module shared_pin_io
    import pin_io_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    // register port
    input  wire logic [3:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_write,
    input  wire logic                   reg_read,
    output logic [7:0]                  reg_rdata,
    // port pins
    input  wire logic [PORT_W-1:0]      pin_in,
    output logic [PORT_W-1:0]           pin_out,
    output logic [PORT_W-1:0]           pin_oe,
    // peripheral side, per pin
    input  wire pin_role_t              pin_role [PORT_W],
    input  wire logic [PORT_W-1:0]      periph_out,
    input  wire logic [PORT_W-1:0]      periph_oe,
    output logic [PORT_W-1:0]           periph_in,
    // interrupt/shutdown pin
    input  wire logic                   forced_shutdown_input,
    output logic                        nmi_level,
    output logic                        shutdown_active,
    // serial output pin
    input  wire logic                   serial_data,
    output logic                        sync_serial_out_pin,
    output logic                        sync_serial_out_oe,
    // three-phase motor pins
    input  wire logic [MOTOR_PINS-1:0]  motor_out,
    output logic [MOTOR_PINS-1:0]       motor_pin_out,
    output logic [MOTOR_PINS-1:0]       motor_pin_oe,
    // open-drain pins
    input  wire logic [OD_PINS-1:0]     od_data,
    output logic [OD_PINS-1:0]          od_pin_out,
    output logic [OD_PINS-1:0]          od_pin_oe,
    // boot mode pin
    input  wire logic                   boot_mode_pin,
    output logic                        boot_pullup_en,
    output logic                        bus_mode
);
    logic [PORT_W-1:0] port_data;         // output latch
    logic [PORT_W-1:0] port_dir;          // 1 = output
    logic [SEL_W-1:0]  filter_clock_select; // irq_filter_ctrl field
    logic              nmi_enable_latch;  // sticky nmi enable
    logic              cutoff_by_input_enable;
    logic              serial_out_disable;
    logic              three_phase_enable;
    logic              three_phase_output_enable;
    logic              mode_switch;       // software processor mode bit
    logic              boot_strap;        // boot pin caught after reset
    logic              strap_taken;       // strap already sampled
    logic              filtered_nmi;      // filter output
    logic              filtered_pin_port_bit; // raw level for port read
    logic              cutoff;            // motor pins forced off
    logic [PORT_W-1:0] periph_drives;     // peripheral owns pin output

    // filter on the interrupt/shutdown input
    nmi_digital_filter u_filter (
        .clk                 (clk),
        .rst                 (rst),
        .filter_clock_select (filter_clock_select),
        .pin_level           (forced_shutdown_input),
        .filtered            (filtered_nmi)
    );

    // boot pin pull-up timer
    boot_pullup_timer u_pullup (
        .clk       (clk),
        .rst       (rst),
        .pullup_on (boot_pullup_en)
    );

    // port latch and direction, inputs after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_data <= DATA_RESET;
            port_dir  <= DIR_RESET; // [RULE13]
        end else if (reg_write) begin
            if (reg_addr == REG_PORT_DATA) begin
                port_data <= reg_wdata;
            end
            if (reg_addr == REG_PORT_DIR) begin
                port_dir <= reg_wdata;
            end
        end
    end

    // filter select and control bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filter_clock_select       <= SEL_RESET;
            cutoff_by_input_enable    <= 1'b0;
            serial_out_disable        <= 1'b0;
            three_phase_enable        <= 1'b0;
            three_phase_output_enable <= 1'b0;
        end else if (reg_write) begin
            if (reg_addr == REG_FILTER_CTRL) begin
                filter_clock_select <= reg_wdata[SEL_W-1:0];
            end
            if (reg_addr == REG_CUTOFF_CTRL) begin
                cutoff_by_input_enable    <= reg_wdata[CUT_EN_BIT];
                serial_out_disable        <= reg_wdata[SOD_BIT];
                three_phase_enable        <= reg_wdata[TP_EN_BIT];
                three_phase_output_enable <= reg_wdata[TP_OE_BIT];
            end
        end
    end

    // nmi enable: writes of 0 have no effect once set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nmi_enable_latch <= 1'b0;
        end else if (reg_write && reg_addr == REG_NMI_CTRL
                     && reg_wdata[0]) begin
            nmi_enable_latch <= 1'b1; // [RULE17]
        end
    end

    // boot strap caught on first clock after reset release
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            boot_strap  <= 1'b0;
            strap_taken <= 1'b0;
        end else if (!strap_taken) begin
            boot_strap  <= boot_mode_pin;
            strap_taken <= 1'b1;
        end
    end

    // processor mode switch by software
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_switch <= 1'b0;
        end else if (reg_write && reg_addr == REG_MODE_CTRL) begin
            mode_switch <= reg_wdata[MODE_BIT];
        end
    end

    // bus_mode low while strap low and mode unchanged; ports held input only until strap taken
    always_comb begin
        bus_mode = strap_taken && (boot_strap || mode_switch); // [RULE14]
    end

    // which pins a peripheral drives; ROLE_PERIPH regardless of direction, ROLE_PWM only with port_dir set
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            unique case (pin_role[i])
                ROLE_PERIPH: periph_drives[i] = periph_oe[i]; // [RULE1]
                ROLE_PWM:    periph_drives[i] = periph_oe[i]
                                                && port_dir[i];
                default:     periph_drives[i] = 1'b0;
            endcase
        end
    end

    // port pin drive: peripheral or latch, inputs until the boot strap is taken
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (!bus_mode && !boot_strap && strap_taken == 1'b0) begin
                pin_out[i] = 1'b0;
                pin_oe[i]  = 1'b0; // [RULE13]
            end else if (periph_drives[i]) begin
                pin_out[i] = periph_out[i]; // [RULE1]
                pin_oe[i]  = 1'b1;
            end else begin
                pin_out[i] = port_data[i];
                pin_oe[i]  = port_dir[i] && (pin_role[i] != ROLE_DAC);
            end
        end
    end

    // every input user sees the same resolved pin level
    always_comb begin
        periph_in = pin_oe & pin_out | ~pin_oe & pin_in; // [RULE3] [RULE4]
    end

    // port input bypasses the filter
    always_comb begin
        filtered_pin_port_bit = forced_shutdown_input; // [RULE7]
    end

    // filtered level to internal circuit
    always_comb begin
        nmi_level       = filtered_nmi;
        shutdown_active = !filtered_nmi;
    end

    // motor pins float on enabled cutoff and low shutdown
    always_comb begin
        cutoff        = cutoff_by_input_enable && !filtered_nmi; // [RULE10]
        motor_pin_out = motor_out;
        motor_pin_oe  = (cutoff || !three_phase_output_enable)
                        ? '0 : '1; // [RULE10]
    end

    // serial output floats when disabled
    always_comb begin
        sync_serial_out_pin = serial_data;
        sync_serial_out_oe  = !serial_out_disable; // [RULE11]
    end

    // open-drain: pull low only on 0
    always_comb begin
        od_pin_out = '0;
        od_pin_oe  = ~od_data; // [RULE15]
    end

    // register read data, one cycle after strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_addr)
                REG_PORT_DATA:   reg_rdata <= port_data;
                REG_PORT_DIR:    reg_rdata <= port_dir;
                REG_FILTER_CTRL: reg_rdata <= 8'(filter_clock_select);
                REG_NMI_CTRL:    reg_rdata <= 8'(nmi_enable_latch);
                REG_CUTOFF_CTRL: reg_rdata <= {4'h0,
                    three_phase_output_enable, three_phase_enable,
                    serial_out_disable, cutoff_by_input_enable};
                REG_MODE_CTRL:   reg_rdata <= 8'(mode_switch);
                REG_STATUS:      reg_rdata <= {4'h0, boot_pullup_en,
                    nmi_enable_latch, filtered_nmi,
                    filtered_pin_port_bit};
                REG_PIN_LEVEL:   reg_rdata <= periph_in;
                default:         reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    a_nmi_sticky: assert property ( // [RULE17]
        @(posedge clk) disable iff (rst)
        nmi_enable_latch |=> nmi_enable_latch)
        else $error("nmi enable cleared after set");

    a_motor_cutoff: assert property ( // [RULE10]
        @(posedge clk) disable iff (rst)
        (cutoff_by_input_enable && !filtered_nmi) |-> motor_pin_oe == '0)
        else $error("motor pins driven during cutoff");

    a_serial_float: assert property ( // [RULE11]
        @(posedge clk) disable iff (rst)
        serial_out_disable |-> !sync_serial_out_oe)
        else $error("serial pin driven while disabled");

    a_od_no_high: assert property ( // [RULE15]
        @(posedge clk) disable iff (rst)
        ((od_pin_oe & od_pin_out) == '0) && (od_pin_oe == ~od_data))
        else $error("open-drain pin drive wrong");

    a_dir_write_lands: assert property ( // [RULE13]
        @(posedge clk) disable iff (rst)
        (reg_write && reg_addr == REG_PORT_DIR)
            |=> port_dir == $past(reg_wdata))
        else $error("direction write lost");

    a_periph_ignores_dir: assert property ( // [RULE1]
        @(posedge clk) disable iff (rst)
        (strap_taken && pin_role[0] == ROLE_PERIPH && periph_oe[0])
            |-> (pin_oe[0] && pin_out[0] == periph_out[0]))
        else $error("peripheral output not driven");

    a_raw_port_read: assert property ( // [RULE7]
        @(posedge clk) disable iff (rst)
        (reg_read && reg_addr == REG_STATUS)
            |=> reg_rdata[ST_RAW_BIT] == $past(forced_shutdown_input))
        else $error("port read not raw");
endmodule
`default_nettype wire

// [test/board_model.sv]
/* board side of the shared port pins: outside drivers and floating lines.
   assumes: pin_out/pin_oe come from the block; one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module board_model (
    input  wire logic [pin_io_pkg::PORT_W-1:0] pin_out,
    input  wire logic [pin_io_pkg::PORT_W-1:0] pin_oe,
    input  wire logic [pin_io_pkg::PORT_W-1:0] ext_en,
    input  wire logic [pin_io_pkg::PORT_W-1:0] ext_val,
    output logic [pin_io_pkg::PORT_W-1:0]      pin_in
);
    import pin_io_pkg::*;
    // resolve each pin from the block and the board
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (pin_oe[i]) begin // block drives
                pin_in[i] = pin_out[i];
            end else if (ext_en[i]) begin // board drives inputs only
                pin_in[i] = ext_val[i];
            end else begin // floating: never a stale copy
                pin_in[i] = ~pin_out[i];
            end
        end
    end
endmodule
`default_nettype wire

// [test/tb_top.sv]
/* self-checking bench for the shared-pin i/o block.
   assumes: board_model resolves the port pins; 100 mhz clock. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import pin_io_pkg::*;
    logic                  clk, rst, reg_write, reg_read;
    logic [3:0]            reg_addr;
    logic [7:0]            reg_wdata, reg_rdata, rv;
    logic [PORT_W-1:0]     pin_in, pin_out, pin_oe, ext_en, ext_val;
    pin_role_t             pin_role [PORT_W];
    logic [PORT_W-1:0]     periph_out, periph_oe, periph_in;
    logic                  sd_in, nmi_level, shutdown_active, serial_data;
    logic                  ser_pin, ser_oe, boot_pin, pu_en, bus_mode;
    logic [MOTOR_PINS-1:0] motor_out, m_out, m_oe;
    logic [OD_PINS-1:0]    od_data, od_out, od_oe;
    int                    fail_count, num_checks, cyc, rel, n;

    shared_pin_io DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_role(pin_role), .periph_out(periph_out),
        .periph_oe(periph_oe), .periph_in(periph_in),
        .forced_shutdown_input(sd_in), .nmi_level(nmi_level),
        .shutdown_active(shutdown_active), .serial_data(serial_data),
        .sync_serial_out_pin(ser_pin), .sync_serial_out_oe(ser_oe),
        .motor_out(motor_out), .motor_pin_out(m_out), .motor_pin_oe(m_oe),
        .od_data(od_data), .od_pin_out(od_out), .od_pin_oe(od_oe),
        .boot_mode_pin(boot_pin), .boot_pullup_en(pu_en),
        .bus_mode(bus_mode));
    board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    // clock and cycle count with hang ceiling
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic t_reset();
        check("pin_oe", pin_oe, 8'h00);
        rd(REG_PORT_DIR, rv);
        check("dir", rv, DIR_RESET);
        check("nmi", {7'h0, nmi_level}, 8'h01);
        check("pullup", {7'h0, pu_en}, 8'h01);
        check("busmode", {7'h0, bus_mode}, 8'h00);
        rd(4'hF, rv);
        check("unmapped", rv, 8'h00);
        n = 0;
        while (pu_en === 1'b1 && n < 2000) begin
            step(1);
            n++;
        end
        n = cyc - rel;
        check("pullup_len", 8'(n == PULLUP_CYC), 8'h01);
        $display("test reset done");
    endtask

    task automatic t_roles();
        periph_out <= 8'hA5;
        periph_oe <= 8'hFF;
        for (int d = 0; d < 2; d++) begin
            wr(REG_PORT_DIR, d ? 8'hFF : 8'h00);
            foreach (pin_role[i]) pin_role[i] <= ROLE_PERIPH;
            step(1);
            check("periph_oe", pin_oe, 8'hFF);
            check("periph_out", pin_out, 8'hA5);
            foreach (pin_role[i]) pin_role[i] <= ROLE_PWM;
            step(1);
            check("pwm_oe", pin_oe, d ? 8'hFF : 8'h00);
        end
        wr(REG_PORT_DATA, 8'h3C);
        foreach (pin_role[i]) pin_role[i] <= ROLE_DAC;
        step(1);
        check("dac_oe", pin_oe, 8'h00);
        foreach (pin_role[i]) pin_role[i] <= ROLE_GPIO;
        step(1);
        check("gpio_oe", pin_oe, 8'hFF);
        check("gpio_out", pin_out, 8'h3C);
        rd(REG_PORT_DATA, rv);
        check("data_rd", rv, 8'h3C);
        $display("test roles done");
    endtask

    task automatic t_fanout();
        wr(REG_PORT_DIR, 8'h00); // pins not driven by peripherals are inputs
        foreach (pin_role[i]) pin_role[i] <= ROLE_PERIPH;
        periph_oe <= 8'h0F;
        periph_out <= 8'h05;
        ext_en <= 8'hF0;
        ext_val <= 8'hA0;
        step(1);
        check("periph_in", periph_in, 8'hA5);
        rd(REG_PIN_LEVEL, rv);
        check("pin_level", rv, 8'hA5);
        $display("test fanout done");
    endtask

    task automatic t_filter(input int sel);
        int per;
        per = 1 << sel;
        wr(REG_FILTER_CTRL, 8'(sel)); // nmi off, motor off
        @(posedge clk);
        sd_in <= 1'b0;
        for (int k = 0; k < 2 * per; k++) begin
            step(1);
            check("glitch", {7'h0, nmi_level}, 8'h01);
        end
        sd_in <= 1'b1;
        step(4 * per + 4);
        sd_in <= 1'b0;
        n = 0;
        while (nmi_level === 1'b1 && n < 60) begin
            step(1);
            n++;
        end
        check("lat", 8'((n > 2 * per) && (n <= 3 * per + 3)),
              8'h01);
        check("sd_act", {7'h0, shutdown_active}, 8'h01);
        sd_in <= 1'b1;
        rd(REG_STATUS, rv);
        check("raw", {6'h0, rv[1:0]}, 8'h01);
        step(4 * per + 4);
        $display("test filter done");
    endtask

    task automatic t_cutoff();
        motor_out <= 6'h2A;
        serial_data <= 1'b1;
        wr(REG_CUTOFF_CTRL, 8'h09);
        check("m_oe_hi", {2'h0, m_oe}, 8'h3F);
        check("m_out", {2'h0, m_out}, 8'h2A);
        check("ser_pin", {7'h0, ser_pin}, 8'h01);
        @(posedge clk);
        sd_in <= 1'b0;
        step(30);
        check("m_oe_cut", {2'h0, m_oe}, 8'h00);
        wr(REG_CUTOFF_CTRL, 8'h08);
        check("m_oe_nocut", {2'h0, m_oe}, 8'h3F);
        sd_in <= 1'b1;
        wr(REG_CUTOFF_CTRL, 8'h02);
        check("ser_off", {7'h0, ser_oe}, 8'h00);
        wr(REG_CUTOFF_CTRL, 8'h00);
        check("ser_on", {7'h0, ser_oe}, 8'h01);
        $display("test cutoff done");
    endtask

    task automatic t_misc();
        for (int d = 0; d < 8; d++) begin
            @(posedge clk);
            od_data <= 3'(d);
            step(1);
            check("od_out", {5'h0, od_out}, 8'h00);
            check("od_oe", {5'h0, od_oe}, {5'h0, ~3'(d)});
        end
        wr(REG_NMI_CTRL, 8'h01);
        wr(REG_NMI_CTRL, 8'h00);
        rd(REG_STATUS, rv);
        check("nmi_en", {7'h0, rv[ST_NMI_BIT]}, 8'h01);
        wr(REG_MODE_CTRL, 8'h01);
        check("busmode_sw", {7'h0, bus_mode}, 8'h01);
        $display("test misc done");
    endtask

    // reset again in mid-run, boot pin strapped high this time
    task automatic t_rereset();
        wr(REG_PORT_DIR, 8'hFF);
        @(posedge clk);
        boot_pin <= 1'b1;
        rst <= 1'b1;
        step(2);
        check("pu_rst", {7'h0, pu_en}, 8'h01);
        check("oe_rst", pin_oe, 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        step(1);
        check("busmode_hi", {7'h0, bus_mode}, 8'h01);
        check("nmi_rst", {7'h0, nmi_level}, 8'h01);
        rd(REG_STATUS, rv);
        check("nmi_en_rst", {7'h0, rv[ST_NMI_BIT]}, 8'h00);
        rd(REG_PORT_DIR, rv);
        check("dir_rst", rv, DIR_RESET);
        $display("test rereset done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // main sequence; upper port registers never touched
    initial begin
        {rst, reg_addr, reg_wdata} = '1;
        {reg_write, reg_read} = 2'b00;
        {periph_out, periph_oe, ext_en, ext_val, motor_out} = '0;
        {od_data, serial_data, boot_pin} = '0;
        foreach (pin_role[i]) pin_role[i] = ROLE_GPIO;
        {fail_count, num_checks, cyc} = '0;
        sd_in = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        step(1);
        rel = cyc - 1; // edge at which reset was released
        t_reset();
        t_roles();
        t_fanout();
        t_filter(0);
        t_filter(2);
        t_cutoff();
        t_misc(); // no wait or stop modeled here
        t_rereset();
        complete_run();
    end
endmodule
`default_nettype wire
